// >>> core/via_controller.sv
// Vectored interrupt controller: acknowledge, nesting and fast path.
// Assumes a one-cycle register port, synchronous source inputs, and
// that the processor reacts to the active-low request lines.
//
// Behaviour
// - Normal vector read makes highest pending enabled source except source 0 current, adopting its level.
// - Normal vector read drops the normal request; software must always read it.
// - Normal vector read clears the selected source only when edge-triggered.
// - Normal vector read pushes new level and source number on the stack.
// - Normal vector read returns the stored handler address of the new current source.
// - A pending enabled source other than source 0 above the current level re-asserts the normal request.
// - End-of-service write pops the stack, restoring the previous level.
// - After a pop, a source other than source 0 above the restored level re-asserts the request.
// - Only source 0 drives the fast request line.
// - Fast path has no arbitration; its priority field still reads back.
// - Source 0 trigger field selects rising, falling, high or low detection.
// - Writing bit 0 to enable or disable command sets or clears source 0.
// - Mask status bit 0 shows whether source 0 is enabled.
// - Fast vector read returns the handler address of source 0.
// - Fast vector register decodes at absolute address FFFF_F104.
// - Fast vector read clears an edge source 0 and only then drops fast request.
// - Priority levels run from 7 highest to 0 lowest.
// - Ties at the top level pick the lowest source number.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/10ps

module via_controller
#(
  parameter int NUM_SOURCES = via_pkg::NUM_SOURCES,
  parameter int STACK_DEPTH = via_pkg::STACK_DEPTH
)
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Register port
  input  wire via_pkg::via_bus_req_t  bus_req,
  output logic [31:0]                 rdata,
  // Interrupt sources, source 0 is the fast one
  input  wire logic [NUM_SOURCES-1:0] src_in,
  // Processor request lines, active low
  output logic                        normal_request_line_n,
  output logic                        fast_request_line_n
);

  // ***************************************************************
  // Local sizes
  // ***************************************************************
  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam int TOP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  // ***************************************************************
  // Functions
  // ***************************************************************

  // Edge or level detection from a mode word
  function automatic logic is_edge(input logic [31:0] mode);
    is_edge = mode[via_pkg::TRIG_LSB];
  endfunction : is_edge

  // Priority field of a mode word
  function automatic logic [via_pkg::PRIO_W-1:0] prio_of
    (input logic [31:0] mode);
    prio_of = mode[via_pkg::PRIO_LSB +: via_pkg::PRIO_W];
  endfunction : prio_of

  // ***************************************************************
  // Storage
  // ***************************************************************
  logic [31:0]               mode_reg   [NUM_SOURCES];
  logic [31:0]               vector_reg [NUM_SOURCES];
  logic [NUM_SOURCES-1:0]    mask_reg;
  logic [NUM_SOURCES-1:0]    edge_pend_reg;
  logic [NUM_SOURCES-1:0]    edge_pend_next;
  logic [NUM_SOURCES-1:0]    src_prev_reg;
  via_pkg::via_stack_entry_t stack_reg  [STACK_DEPTH];
  logic [SP_W-1:0]           sp_reg;
  logic [31:0]               rdata_reg;
  logic                      normal_req_n_reg;
  logic                      fast_req_n_reg;

  // ***************************************************************
  // Address decode
  // ***************************************************************
  logic                   in_space;
  logic [11:0]            ofs;
  localparam int SRC_W_IDX = via_pkg::SRC_W;
  logic [SRC_W_IDX-1:0]   reg_idx;
  logic                   hit_mode;
  logic                   hit_vector;
  logic                   normal_vec_rd;
  logic                   fast_vec_rd;
  logic                   enable_wr;
  logic                   disable_wr;
  logic                   eos_wr;

  // Whole upper address is compared so the vectors sit at absolute spots
  assign in_space   = bus_req.addr[31:12] == via_pkg::BASE_ADDR[31:12];
  assign ofs        = bus_req.addr[11:0];
  assign reg_idx    = ofs[6:2];
  assign hit_mode   = in_space && (ofs[11:7] == 5'h00)
                      && (32'(reg_idx) < NUM_SOURCES);
  assign hit_vector = in_space && (ofs[11:7] == 5'h01)
                      && (32'(reg_idx) < NUM_SOURCES);

  // Strobes last one cycle, so each read acts exactly once
  assign normal_vec_rd = bus_req.rd && in_space
                         && ofs == via_pkg::NORMAL_VECTOR_REGISTER_OFS;
  assign fast_vec_rd   = bus_req.rd && in_space
                         && ofs == via_pkg::FAST_VECTOR_REGISTER_OFS;
  assign enable_wr     = bus_req.wr && in_space
                         && ofs == via_pkg::ENABLE_COMMAND_REGISTER_OFS;
  assign disable_wr    = bus_req.wr && in_space
                         && ofs == via_pkg::DISABLE_COMMAND_REGISTER_OFS;
  assign eos_wr        = bus_req.wr && in_space
                         && ofs == via_pkg::END_OF_SERVICE_REGISTER_OFS;

  // ***************************************************************
  // Source detection
  // ***************************************************************
  logic [NUM_SOURCES-1:0] edge_hit;
  logic [NUM_SOURCES-1:0] level_hit;
  logic [NUM_SOURCES-1:0] pending;
  logic [NUM_SOURCES-1:0] active;

  // Four detection modes per source, source 0 included
  always_comb
  begin
    for (int n = 0; n < NUM_SOURCES; n++)
    begin
      edge_hit[n]  = 1'b0;
      level_hit[n] = 1'b0;
      case (via_pkg::via_trig_t'(mode_reg[n][via_pkg::TRIG_LSB +: 2]))
        via_pkg::TRIG_HIGH_LEVEL: level_hit[n] = src_in[n];
        via_pkg::TRIG_LOW_LEVEL:  level_hit[n] = !src_in[n];
        via_pkg::TRIG_RISING:
          edge_hit[n] = src_in[n] && !src_prev_reg[n];
        via_pkg::TRIG_FALLING:
          edge_hit[n] = !src_in[n] && src_prev_reg[n];
        default:
        begin
          edge_hit[n]  = 1'b0;
          level_hit[n] = 1'b0;
        end
      endcase
      // Level sources follow the pin; a vector read never clears them
      pending[n] = is_edge(mode_reg[n]) ? edge_pend_reg[n]
                                        : level_hit[n];
    end
    active = pending & mask_reg;
  end

  // ***************************************************************
  // Current level and arbitration
  // ***************************************************************
  logic                           cur_valid;
  logic [TOP_W-1:0]               top_idx;
  via_pkg::via_stack_entry_t      cur_entry;
  logic                           sel_found;
  logic [via_pkg::SRC_W-1:0]      sel_num;
  logic [via_pkg::PRIO_W-1:0]     sel_prio;

  assign cur_valid = sp_reg != '0;
  assign top_idx   = TOP_W'(sp_reg - SP_W'(1));
  assign cur_entry = stack_reg[top_idx];

  // Walk downward so an equal level keeps replacing with lower numbers
  always_comb
  begin
    sel_found = 1'b0;
    sel_num   = '0;
    sel_prio  = '0;
    for (int n = NUM_SOURCES - 1; n >= 1; n--)
    begin
      if (active[n]
          && (!cur_valid || prio_of(mode_reg[n]) > cur_entry.level)
          && (!sel_found || prio_of(mode_reg[n]) >= sel_prio))
      begin
        sel_found = 1'b1;
        sel_num   = via_pkg::SRC_W'(n);
        sel_prio  = prio_of(mode_reg[n]);
      end
    end
  end

  // ***************************************************************
  // Configuration registers
  // ***************************************************************

  // Mode and vector words; priority of source 0 is kept for readback only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int n = 0; n < NUM_SOURCES; n++)
      begin
        mode_reg[n]   <= via_pkg::MODE_RESET;
        vector_reg[n] <= via_pkg::VECTOR_RESET;
      end
    end
    else if (bus_req.wr)
    begin
      if (hit_mode)
        mode_reg[reg_idx] <= bus_req.wdata & via_pkg::MODE_WMASK;
      if (hit_vector)
        vector_reg[reg_idx] <= bus_req.wdata;
    end
  end

  // Enable mask: set and clear commands are bit masks, bit 0 is source 0
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mask_reg <= '0;
    else if (enable_wr)
      mask_reg <= mask_reg | bus_req.wdata[NUM_SOURCES-1:0];
    else if (disable_wr)
      mask_reg <= mask_reg & ~bus_req.wdata[NUM_SOURCES-1:0];
  end

  // ***************************************************************
  // Edge memory
  // ***************************************************************

  // A new edge in the clearing cycle wins, so no event is lost
  always_comb
  begin
    for (int n = 0; n < NUM_SOURCES; n++)
    begin
      edge_pend_next[n] = (edge_hit[n] && is_edge(mode_reg[n]))
        || (edge_pend_reg[n]
            && !(normal_vec_rd && sel_found
                 && sel_num == via_pkg::SRC_W'(n))
            && !(fast_vec_rd && n == 0));
    end
  end

  // Edge sticky bits and previous input sample
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      edge_pend_reg <= '0;
      src_prev_reg  <= '0;
    end
    else
    begin
      edge_pend_reg <= edge_pend_next;
      src_prev_reg  <= src_in;
    end
  end

  // ***************************************************************
  // Nesting stack
  // ***************************************************************

  // Push on acknowledge, pop on end of service; a full stack drops pushes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sp_reg <= '0;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack_reg[i] <= '0;
    end
    else if (normal_vec_rd && sel_found
             && 32'(sp_reg) < STACK_DEPTH)
    begin
      stack_reg[TOP_W'(sp_reg)] <= '{level: sel_prio,
                                     number: sel_num};
      sp_reg <= sp_reg + SP_W'(1);
    end
    else if (eos_wr && cur_valid)
      sp_reg <= sp_reg - SP_W'(1);
  end

  // ***************************************************************
  // Request lines
  // ***************************************************************

  // Forced high in the acknowledge cycle, since the stack moves only then
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      normal_req_n_reg <= 1'b1;
    else if (normal_vec_rd)
      normal_req_n_reg <= 1'b1;
    else
      normal_req_n_reg <= !sel_found;
  end

  // Fast line: source 0 only, no arbitration; a level source stays asserted
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fast_req_n_reg <= 1'b1;
    else if (fast_vec_rd && is_edge(mode_reg[0]))
      fast_req_n_reg <= 1'b1;
    else
      fast_req_n_reg <= !active[0];
  end

  // ***************************************************************
  // Read data
  // ***************************************************************

  // Unmapped or write-only offsets read as zero; data valid one cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_reg <= '0;
    else if (!bus_req.rd)
      rdata_reg <= '0;
    else if (hit_mode)
      rdata_reg <= mode_reg[reg_idx];
    else if (hit_vector)
      rdata_reg <= vector_reg[reg_idx];
    else if (normal_vec_rd)
      rdata_reg <= sel_found ? vector_reg[sel_num] : 32'h0000_0000;
    else if (fast_vec_rd)
      rdata_reg <= vector_reg[0];
    else if (in_space && ofs == via_pkg::MASK_STATUS_REGISTER_OFS)
      rdata_reg <= 32'(mask_reg);
    else if (in_space && ofs == via_pkg::CURRENT_SOURCE_REGISTER_OFS)
    begin
      rdata_reg <= '0;
      rdata_reg[via_pkg::SRC_W-1:0] <= cur_valid ? cur_entry.number
                                                 : '0;
      rdata_reg[via_pkg::CUR_LEVEL_LSB +: via_pkg::PRIO_W] <=
        cur_valid ? cur_entry.level : '0;
      rdata_reg[via_pkg::CUR_VALID_BIT] <= cur_valid;
    end
    else
      rdata_reg <= '0;
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign rdata                 = rdata_reg;
  assign normal_request_line_n = normal_req_n_reg;
  assign fast_request_line_n   = fast_req_n_reg;

endmodule : via_controller

// >>> inc/via_pkg.sv
// Shared constants and types of the vectored interrupt acknowledge block.
// Assumes a 32-bit byte address bus and a 4 KB register window.
package via_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int NUM_SOURCES = 32;
  localparam int STACK_DEPTH = 8;
  localparam int SRC_W       = 5;
  localparam int PRIO_W      = 3;

  // ***************************************************************
  // Address map
  // ***************************************************************
  localparam logic [31:0] BASE_ADDR                     = 32'hFFFF_F000;
  localparam logic [11:0] SOURCE_MODE_REGISTER_OFS      = 12'h000;
  localparam logic [11:0] SOURCE_VECTOR_REGISTER_OFS    = 12'h080;
  localparam logic [11:0] NORMAL_VECTOR_REGISTER_OFS    = 12'h100;
  localparam logic [11:0] FAST_VECTOR_REGISTER_OFS      = 12'h104;
  localparam logic [11:0] CURRENT_SOURCE_REGISTER_OFS   = 12'h108;
  localparam logic [11:0] MASK_STATUS_REGISTER_OFS      = 12'h110;
  localparam logic [11:0] ENABLE_COMMAND_REGISTER_OFS   = 12'h120;
  localparam logic [11:0] DISABLE_COMMAND_REGISTER_OFS  = 12'h124;
  localparam logic [11:0] END_OF_SERVICE_REGISTER_OFS   = 12'h130;

  // ***************************************************************
  // Field layouts and reset values
  // ***************************************************************
  localparam int          PRIO_LSB       = 0;
  localparam int          TRIG_LSB       = 5;
  localparam logic [31:0] MODE_WMASK     = 32'h0000_0067;
  localparam logic [31:0] MODE_RESET     = 32'h0000_0000;
  localparam logic [31:0] VECTOR_RESET   = 32'h0000_0000;
  localparam int          CUR_LEVEL_LSB  = 8;
  localparam int          CUR_VALID_BIT  = 16;

  // Trigger type; bit 0 set means edge detection
  typedef enum logic [1:0]
  {
    TRIG_HIGH_LEVEL = 2'h0,
    TRIG_RISING     = 2'h1,
    TRIG_LOW_LEVEL  = 2'h2,
    TRIG_FALLING    = 2'h3
  } via_trig_t;

  // Register bus request from the master
  typedef struct packed
  {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } via_bus_req_t;

  // One entry of the nesting stack
  typedef struct packed
  {
    logic [PRIO_W-1:0] level;
    logic [SRC_W-1:0]  number;
  } via_stack_entry_t;

endpackage : via_pkg

// >>> verification/via_ctrl_sva.sv
// Checker of the acknowledge block, watching the top ports only.
// Assumes a one-cycle strobe master and one clock domain.
`timescale 1ns/10ps
module via_ctrl_sva
#(
  parameter int NUM_SOURCES = 32
)
(
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // Register port
  input wire via_pkg::via_bus_req_t  bus_req,
  input wire logic [31:0]            rdata,
  // Sources and request lines
  input wire logic [NUM_SOURCES-1:0] src_in,
  input wire logic                   normal_request_line_n,
  input wire logic                   fast_request_line_n
);
  // ******************************
  // Shadow state and properties
  // ******************************
  logic [31:0] en_reg, mode0_reg, vec0_reg, wd;
  logic [11:0] ofs;
  logic        hit, fvr_rd, ivr_rd, act0;
  // Decode of the strobes, absolute window only
  assign wd     = bus_req.wdata;
  assign ofs    = bus_req.addr[11:0];
  assign hit    = bus_req.addr[31:12] == 20'hFFFFF;
  assign fvr_rd = bus_req.rd && hit && ofs == 12'h104;
  assign ivr_rd = bus_req.rd && hit && ofs == 12'h100;
  assign act0   = src_in[0] ^ mode0_reg[6]; // Level polarity of source 0
  // Shadow of the enable mask, mode 0 and vector 0
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      en_reg    <= '0;
      mode0_reg <= '0;
      vec0_reg  <= '0;
    end
    else if (bus_req.wr && hit)
    begin
      case (ofs)
        12'h120: en_reg    <= en_reg | wd;
        12'h124: en_reg    <= en_reg & ~wd;
        12'h000: mode0_reg <= wd & via_pkg::MODE_WMASK;
        12'h080: vec0_reg  <= wd;
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rd_zero; !$past(bus_req.rd) |-> rdata == 32'h0; endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("read data outside the answer cycle");
  property p_fvr_data; fvr_rd |=> rdata == vec0_reg; endproperty
  a_fvr_data: assert property (p_fvr_data)
    else $error("fast vector data wrong");
  property p_mode0_rb;
    bus_req.rd && hit && ofs == 12'h000 |=> rdata == mode0_reg;
  endproperty
  a_mode0_rb: assert property (p_mode0_rb)
    else $error("mode 0 read back wrong");
  property p_msr;
    bus_req.rd && hit && ofs == 12'h110 |=> rdata == en_reg;
  endproperty
  a_msr: assert property (p_msr)
    else $error("mask status wrong");
  property p_fvr_edge;
    fvr_rd && mode0_reg[5] |-> ##[1:2] fast_request_line_n;
  endproperty
  a_fvr_edge: assert property (p_fvr_edge)
    else $error("fast line kept after edge read");
  property p_fast_lvl;
    (en_reg[0] && !mode0_reg[5] && act0)[*3] |-> !fast_request_line_n;
  endproperty
  a_fast_lvl: assert property (p_fast_lvl)
    else $error("active level source 0 not requested");
  property p_fast_off; (!en_reg[0])[*3] |-> fast_request_line_n; endproperty
  a_fast_off: assert property (p_fast_off)
    else $error("fast line while disabled");
  property p_norm_off;
    (en_reg[31:1] == 31'h0)[*3] |-> normal_request_line_n;
  endproperty
  a_norm_off: assert property (p_norm_off)
    else $error("normal line with no normal source enabled");
  property p_ivr_drop; ivr_rd |-> ##[1:2] normal_request_line_n; endproperty
  a_ivr_drop: assert property (p_ivr_drop)
    else $error("normal line kept after vector read");

  c_fvr: cover property (fvr_rd && !fast_request_line_n);
  c_ivr: cover property (ivr_rd && !normal_request_line_n);
  c_eos: cover property (bus_req.wr && hit && ofs == 12'h130);
endmodule : via_ctrl_sva

bind via_controller via_ctrl_sva #(.NUM_SOURCES(NUM_SOURCES)) u_sva
(
  .clk                   (clk),
  .rst_n                 (rst_n),
  .bus_req               (bus_req),
  .rdata                 (rdata),
  .src_in                (src_in),
  .normal_request_line_n (normal_request_line_n),
  .fast_request_line_n   (fast_request_line_n)
);

// >>> verification/via_core_model.sv
// Processor core model: bus master and handler entry sequences.
// Assumes the controller answers reads in the cycle after the strobe.
`timescale 1ns/10ps
module via_core_model
(
  // Clock
  input  wire logic             clk,
  // Register port
  output via_pkg::via_bus_req_t bus_req,
  input  wire logic [31:0]      rdata,
  // Request lines, active low
  input  wire logic             normal_request_line_n,
  input  wire logic             fast_request_line_n
);
  // ******************************
  // Bus cycles
  // ******************************
  initial bus_req = '0;
  // Released lines show the inverse so stale values never match
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'h1;
    @(posedge clk);
    bus_req.wr    <= 1'h0;
    bus_req.addr  <= ~a;
    bus_req.wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'h1;
    @(posedge clk);
    bus_req.rd   <= 1'h0;
    bus_req.addr <= ~a;
    #1 d = rdata;
  endtask : rd
  // Entry reads the normal vector even if unused
  task automatic ack_normal(output logic [31:0] v);
    rd(32'hFFFF_F100, v);
  endtask : ack_normal
  task automatic end_service;
    wr(32'hFFFF_F130, 32'h0);
  endtask : end_service
  // Handler at the fast vector reads the fast vector first
  task automatic fast_entry(output logic [31:0] v);
    rd(32'hFFFF_F104, v);
  endtask : fast_entry
  // Bounded wait for a request line to go low
  task automatic wait_low(input logic fast, output logic ok);
    ok = 1'h0;
    for (int i = 0; i < 20 && !ok; i++)
    begin
      @(posedge clk);
      #1 ok = !(fast ? fast_request_line_n : normal_request_line_n);
    end
  endtask : wait_low
endmodule : via_core_model

// >>> verification/tb.sv
// Self-checking bench of the vectored interrupt acknowledge block.
// Assumes the core model owns the bus and the bench drives sources.
`timescale 1ns/10ps
`define CHK(n, e, g) if ((g) !== (e)) note(n, 32'(e), 32'(g)); else check_count++;
module tb;
  // ******************************
  // Harness and scenarios
  // ******************************
  logic                  clk, rst_n;
  logic [31:0]           rdata, src_in;
  logic                  normal_request_line_n, fast_request_line_n;
  via_pkg::via_bus_req_t bus_req;
  int                    n_errors = 0;
  int                    check_count = 0;

  via_controller dut
  (
    .clk                   (clk),
    .rst_n                 (rst_n),
    .bus_req               (bus_req),
    .rdata                 (rdata),
    .src_in                (src_in),
    .normal_request_line_n (normal_request_line_n),
    .fast_request_line_n   (fast_request_line_n)
  );
  via_core_model core
  (
    .clk                   (clk),
    .bus_req               (bus_req),
    .rdata                 (rdata),
    .normal_request_line_n (normal_request_line_n),
    .fast_request_line_n   (fast_request_line_n)
  );

  // 25 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] ad(input logic [11:0] o);
    return via_pkg::BASE_ADDR | {20'h0, o};
  endfunction : ad
  task automatic note(input string n, input logic [31:0] e, g);
    n_errors++;
    check_count++;
    $display("[ERR] %s expected %h seen %h", n, e, g);
  endtask : note
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // A hang counts as a mismatch and ends the run
  task automatic wt(input logic fast);
    logic ok;
    core.wait_low(fast, ok);
    `CHK("request wait", 1'h1, ok)
    if (!ok)
      end_sim();
  endtask : wt

  // Reset values and unmapped places read zero
  task automatic t_reset;
    logic [31:0] v;
    core.rd(ad(12'h110), v);
    `CHK("mask status", 32'h0, v)
    core.ack_normal(v);
    `CHK("idle vector", 32'h0, v)
    core.rd(ad(12'h1F0), v);
    `CHK("unmapped", 32'h0, v)
    core.rd(32'h0000_0104, v);
    `CHK("outside window", 32'h0, v)
  endtask : t_reset

  // Every trigger type of source 0, edge reads clear, levels hold
  task automatic t_fast;
    logic [31:0] v;
    logic [1:0]  m;
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(i);
      @(posedge clk);
      src_in[0] <= m[1];
      core.wr(ad(12'h000), {24'hFF, 1'h1, m, 5'h1F});
      core.wr(ad(12'h080), {16'hF0F0, 14'h0, m});
      core.wr(ad(12'h120), 32'h1);
      core.rd(ad(12'h000), v);
      `CHK("mode 0", {25'h0, m, 5'h07}, v)
      core.rd(ad(12'h110), v);
      `CHK("mask on", 32'h1, v)
      @(posedge clk);
      src_in[0] <= ~m[1];
      wt(1'h1);
      `CHK("normal quiet", 1'h1, normal_request_line_n)
      core.fast_entry(v);
      `CHK("fast vector", {16'hF0F0, 14'h0, m}, v)
      repeat (2) @(posedge clk);
      #1 `CHK("fast after read", m[0], fast_request_line_n)
      @(posedge clk);
      src_in[0] <= m[1];
      core.wr(ad(12'h124), 32'h1);
      repeat (3) @(posedge clk);
      #1 `CHK("fast released", 1'h1, fast_request_line_n)
      core.rd(ad(12'h110), v);
      `CHK("mask off", 32'h0, v)
    end
  endtask : t_fast

  // Tie, nesting, pop and level versus edge clearing
  task automatic t_normal;
    logic [31:0] v;
    core.wr(ad(12'h00C), 32'h24);
    core.wr(ad(12'h014), 32'h04);
    core.wr(ad(12'h01C), 32'h26);
    for (int n = 3; n < 8; n += 2)
      core.wr(ad(12'h080 + 12'(4 * n)), 32'hA000 + n);
    core.wr(ad(12'h120), 32'hA8);
    @(posedge clk);
    src_in[5:3] <= 3'h5;
    wt(1'h0);
    core.ack_normal(v);
    `CHK("tie vector", 32'hA003, v)
    core.rd(ad(12'h108), v);
    `CHK("current 3", 32'h0001_0403, v)
    `CHK("normal dropped", 1'h1, normal_request_line_n)
    @(posedge clk);
    src_in[7] <= 1'h1;
    wt(1'h0);
    core.ack_normal(v);
    `CHK("nested vector", 32'hA007, v)
    core.rd(ad(12'h108), v);
    `CHK("current 7", 32'h0001_0607, v)
    core.end_service();
    core.rd(ad(12'h108), v);
    `CHK("popped", 32'h0001_0403, v)
    `CHK("equal level quiet", 1'h1, normal_request_line_n)
    core.end_service();
    wt(1'h0);
    core.ack_normal(v);
    `CHK("edge cleared", 32'hA005, v)
    core.end_service();
    wt(1'h0);
    core.ack_normal(v);
    `CHK("level kept", 32'hA005, v)
    @(posedge clk);
    src_in[5] <= 1'h0;
    core.end_service();
    repeat (3) @(posedge clk);
    #1 `CHK("all served", 1'h1, normal_request_line_n)
  endtask : t_normal

  // Main sequence
  initial
  begin
    rst_n  = 1'h0;
    src_in = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_fast();
    t_normal();
    end_sim();
  end
endmodule : tb
